// ### bench/cva_mon_model.sv
// Purpose: horizontal timing side seen by the block: char clock, line end, display enable
// Assumes: pulses are one cycle wide and change on the falling edge
// Notes:   pulses are spaced by idle cycles, so no two land on the same edge
`timescale 1ns/1ns
module cva_mon_model (
  input  wire logic ref_clk_i,
  output logic      char_clk_en_o,
  output logic      line_end_o,
  output logic      disp_en_o
);
  ////////////////////////////////////////////////////////////////////////////
  // idle levels from time zero
  initial begin
    char_clk_en_o = 1'b0;
    line_end_o = 1'b0;
    disp_en_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // n character clocks, then let the registered address settle
  task automatic chars(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk_i);
      char_clk_en_o = 1'b1;
      @(negedge ref_clk_i);
      char_clk_en_o = 1'b0;
    end
    repeat (3) @(negedge ref_clk_i);
  endtask

  // one scan line end; three idle cycles cover the two-stage output lag
  task automatic line();
    @(negedge ref_clk_i);
    line_end_o = 1'b1;
    @(negedge ref_clk_i);
    line_end_o = 1'b0;
    repeat (3) @(negedge ref_clk_i);
  endtask

  // display enable is a level, held until the next call
  task automatic set_disp(input logic b);
    @(negedge ref_clk_i);
    disp_en_o = b;
  endtask
endmodule

// ### bench/cva_top_tb_top.sv
// Purpose: self-checking bench for the vertical and address control block
// Assumes: cva_mon_model drives the horizontal timing pulses
// Notes:   inputs change on the falling edge; outputs are checked once settled
`timescale 1ns/1ns
module cva_top_tb_top;
  localparam logic [7:0] UL = cva_pkg::CVA_IDX_UNDERLINE;
  localparam logic [7:0] VS = cva_pkg::CVA_IDX_VBSTART;
  localparam logic [7:0] VE = cva_pkg::CVA_IDX_VBEND;
  localparam logic [7:0] MD = cva_pkg::CVA_IDX_MODE;
  localparam logic [7:0] LC = cva_pkg::CVA_IDX_LCOMPARE;
  logic        ref_clk_i     = 1'b0;
  logic        sys_rst_i     = 1'b1;
  logic [15:0] io_addr_i     = 16'h0000;
  logic        io_wr_i       = 1'b0;
  logic        io_rd_i       = 1'b0;
  logic [7:0]  io_wdata_i    = 8'h00;
  logic        color_emul_i  = 1'b1;
  logic [1:0]  vbs_hi_i      = 2'h0;
  logic [1:0]  lcmp_hi_i     = 2'h3;
  logic [4:0]  max_scan_i    = 5'h00;
  logic [9:0]  vtotal_i      = 10'h3FF;
  logic [15:0] start_addr_i  = 16'h0000;
  logic [7:0]  line_offset_i = 8'h00;
  logic        pan_compat_i  = 1'b0;
  logic [3:0]  pan_i         = 4'h0;
  logic        char_en;
  logic        line_end;
  logic        disp_en;
  logic [7:0]  io_rdata_o;
  logic [15:0] mem_addr_o;
  logic        vblank_o;
  logic        underline_o;
  logic        split_o;
  logic [3:0]  pan_o;
  logic [9:0]  scan_line_o;
  int          num_errors    = 0;
  int          checked       = 0;
  int          cycles        = 0;

  ////////////////////////////////////////////////////////////////////////////
  // block under test and its timing partner
  cva_top u_cva_top (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .color_emul_i(color_emul_i), .vbs_hi_i(vbs_hi_i),
    .lcmp_hi_i(lcmp_hi_i), .max_scan_i(max_scan_i), .vtotal_i(vtotal_i), .start_addr_i(start_addr_i),
    .line_offset_i(line_offset_i), .char_clk_en_i(char_en), .line_end_i(line_end), .disp_en_i(disp_en),
    .pan_compat_i(pan_compat_i), .pan_i(pan_i), .io_rdata_o(io_rdata_o), .mem_addr_o(mem_addr_o),
    .vblank_o(vblank_o), .underline_o(underline_o), .split_o(split_o), .pan_o(pan_o), .scan_line_o(scan_line_o));
  cva_mon_model u_cva_mon_model (.ref_clk_i(ref_clk_i), .char_clk_en_o(char_en), .line_end_o(line_end),
    .disp_en_o(disp_en));

  // 125 MHz clock and a hang guard well above the run length
  always #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one i/o strobe; the gap cycle keeps strobes from merging between calls
  task automatic io_cyc(input logic [15:0] a, input logic [7:0] d, input logic rd);
    @(negedge ref_clk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = !rd;
    io_rd_i = rd;
    @(negedge ref_clk_i);
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
  endtask

  // c selects the colour pair, else the mono pair
  task automatic reg_write(input logic c, input logic [7:0] idx, input logic [7:0] d);
    io_cyc(c ? cva_pkg::CVA_IDX_PORT_COLOR : cva_pkg::CVA_IDX_PORT_MONO, idx, 1'b0);
    io_cyc(c ? cva_pkg::CVA_DATA_PORT_COLOR : cva_pkg::CVA_DATA_PORT_MONO, d, 1'b0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    reg_write(1'b1, idx, d);
  endtask

  task automatic reg_read(input logic c, input logic [7:0] idx, output logic [7:0] d);
    io_cyc(c ? cva_pkg::CVA_IDX_PORT_COLOR : cva_pkg::CVA_IDX_PORT_MONO, idx, 1'b0);
    io_cyc(c ? cva_pkg::CVA_DATA_PORT_COLOR : cva_pkg::CVA_DATA_PORT_MONO, 8'h00, 1'b1);
    @(negedge ref_clk_i);
    d = io_rdata_o;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reset values, reserved bits, unmapped index, port pair decode
  task automatic t_regs();
    logic [7:0] d;
    for (int i = 0; i < 5; i++) begin
      reg_read(1'b1, UL + 8'(i), d);
      check(16'(d), 16'h0000);
      wr(UL + 8'(i), 8'hFF);
      reg_read(1'b1, UL + 8'(i), d);
      check(16'(d), (i == 0 || i == 2) ? 16'h007F : (i == 3) ? 16'h00EF : 16'h00FF);
    end
    wr(8'h19, 8'hFF);
    reg_read(1'b1, 8'h19, d);
    check(16'(d), 16'h0000);
    reg_write(1'b0, VS, 8'h5A);
    reg_read(1'b1, VS, d);
    check(16'(d), 16'h00FF);
    reg_read(1'b0, VS, d);
    check(16'(d), 16'h0000);
    color_emul_i = 1'b0;
    reg_write(1'b0, VS, 8'h5A);
    reg_read(1'b0, VS, d);
    check(16'(d), 16'h005A);
    color_emul_i = 1'b1;
  endtask

  // eight char clocks under undivided, count-by-two, and count-by-four over two
  task automatic t_count();
    u_cva_mon_model.set_disp(1'b1);
    for (int k = 0; k < 3; k++) begin
      wr(UL, (k == 2) ? 8'h20 : 8'h00);
      wr(MD, (k == 0) ? 8'hC3 : 8'hCB);
      u_cva_mon_model.line();
      u_cva_mon_model.chars(8);
      check(mem_addr_o, 16'h0008 >> k);
    end
  endtask

  // every line wraps the frame so the counter holds the start address
  task automatic t_map();
    logic [15:0] sa;
    logic [15:0] exp;
    sa = 16'h85C3;
    start_addr_i = sa;
    vtotal_i = 10'h000;
    // run bit clear zeroes the line counter so every line below wraps the frame
    wr(MD, 8'h00);
    u_cva_mon_model.set_disp(1'b0);
    for (int k = 0; k < 4; k++) begin
      wr(UL, (k == 3) ? 8'h40 : 8'h00);
      wr(MD, (k == 0) ? 8'hC3 : (k == 1) ? 8'h83 : 8'hA3);
      u_cva_mon_model.line();
      case (k)
        0: exp = sa;
        1: exp = {sa[14:0], sa[13]};
        2: exp = {sa[14:0], sa[15]};
        default: exp = {sa[13:0], sa[15:14]};
      endcase
      check(mem_addr_o, exp);
    end
  endtask

  // row 3 of a 4-row character: row bits replace address bits 13 and 14
  task automatic t_rowsub();
    logic [15:0] exp;
    vtotal_i = 10'h3FF;
    max_scan_i = 5'h03;
    wr(UL, 8'h02);
    wr(MD, 8'hC0);
    u_cva_mon_model.set_disp(1'b1);
    for (int k = 1; k < 4; k++) begin
      u_cva_mon_model.line();
      check(underline_o, k == 2);
    end
    for (int m = 0; m < 4; m++) begin
      wr(MD, 8'hC0 | 8'(m));
      repeat (3) @(negedge ref_clk_i);
      exp = 16'h85C3;
      exp[13] = m[0] ? exp[13] : 1'b1;
      exp[14] = m[1] ? exp[14] : 1'b1;
      check(mem_addr_o, exp);
    end
  endtask

  // 10-bit blank start 258, width 3, split at 259 with panning locked
  task automatic t_vert();
    vtotal_i = 10'h000;
    start_addr_i = 16'h1234;
    // clear the counters first, the previous scenario left the line count above zero
    wr(MD, 8'h00);
    wr(MD, 8'hC3);
    u_cva_mon_model.set_disp(1'b0);
    u_cva_mon_model.line();
    max_scan_i = 5'h00;
    vtotal_i = 10'h3FF;
    vbs_hi_i = 2'h1;
    lcmp_hi_i = 2'h1;
    pan_compat_i = 1'b1;
    pan_i = 4'h5;
    wr(VS, 8'h02);
    wr(VE, 8'((10'h102 + 10'h004 - 10'h001) & 10'h07F));
    wr(LC, 8'h03);
    for (int l = 1; l < 263; l++) begin
      u_cva_mon_model.line();
      check(16'(scan_line_o), 16'(l));
      check(vblank_o, l >= 258 && l < 261);
      check(split_o, l >= 259);
      if (l == 258 || l == 259) begin
        check(mem_addr_o, (l == 258) ? 16'h1234 : 16'h0000);
        check(16'(pan_o), (l == 258) ? 16'h0005 : 16'h0000);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: reset for 20 cycles, then each scenario in turn
  initial begin
    repeat (20) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    t_regs();
    t_count();
    t_map();
    t_rowsub();
    t_vert();
    stop_test();
  end
endmodule

// ### shared/cva_cfg_if.sv
// Purpose: carries the programmed register bytes from the register file to the core
// Assumes: one writer (register file), readers in the core
// Notes:   plain bytes; the core picks its fields by package positions
`timescale 1ns/1ns
interface cva_cfg_if;
  logic [7:0] ul;
  logic [7:0] vbs;
  logic [7:0] vbe;
  logic [7:0] mode;
  logic [7:0] lcmp;
  modport regs (output ul, output vbs, output vbe, output mode, output lcmp);
  modport core (input ul, input vbs, input vbe, input mode, input lcmp);
endinterface

// ### shared/cva_pkg.sv
// Purpose: shared constants and types for the vertical and address control block
// Assumes: 8-bit indexed i/o register access, character-clock enable pulses
// Notes:   every offset, field position and reset value is named here once
package cva_pkg;

  // i/o ports; the emulation-select input picks the mono or colour pair
  localparam logic [15:0] CVA_IDX_PORT_MONO   = 16'h03B4;
  localparam logic [15:0] CVA_DATA_PORT_MONO  = 16'h03B5;
  localparam logic [15:0] CVA_IDX_PORT_COLOR  = 16'h03D4;
  localparam logic [15:0] CVA_DATA_PORT_COLOR = 16'h03D5;

  // register indices behind the data port
  localparam logic [7:0] CVA_IDX_UNDERLINE = 8'h14;
  localparam logic [7:0] CVA_IDX_VBSTART   = 8'h15;
  localparam logic [7:0] CVA_IDX_VBEND     = 8'h16;
  localparam logic [7:0] CVA_IDX_MODE      = 8'h17;
  localparam logic [7:0] CVA_IDX_LCOMPARE  = 8'h18;

  // reset values
  localparam logic [7:0] CVA_RST_INDEX     = 8'h00;
  localparam logic [7:0] CVA_RST_UNDERLINE = 8'h00;
  localparam logic [7:0] CVA_RST_VBSTART   = 8'h00;
  localparam logic [7:0] CVA_RST_VBEND     = 8'h00;
  localparam logic [7:0] CVA_RST_MODE      = 8'h00;
  localparam logic [7:0] CVA_RST_LCOMPARE  = 8'h00;

  // writable-bit masks; reserved bits stay zero
  localparam logic [7:0] CVA_MASK_UNDERLINE = 8'h7F;
  localparam logic [7:0] CVA_MASK_VBSTART   = 8'hFF;
  localparam logic [7:0] CVA_MASK_VBEND     = 8'h7F;
  localparam logic [7:0] CVA_MASK_MODE      = 8'hEF;
  localparam logic [7:0] CVA_MASK_LCOMPARE  = 8'hFF;

  // field positions
  localparam int CVA_UL_ROW_MSB    = 4;
  localparam int CVA_UL_CNT4_BIT   = 5;
  localparam int CVA_UL_DWORD_BIT  = 6;
  localparam int CVA_VBE_MSB       = 6;
  localparam int CVA_MODE_COMPAT   = 0;
  localparam int CVA_MODE_ROWSEL   = 1;
  localparam int CVA_MODE_CNT2     = 3;
  localparam int CVA_MODE_WRAP     = 5;
  localparam int CVA_MODE_BYTE     = 6;
  localparam int CVA_MODE_RUN      = 7;

  // divided character clock phase that advances the address counter
  localparam logic [1:0] CVA_DIV4_LAST = 2'h3;

  // memory addressing mode
  typedef enum logic [2:0] {
    CVA_AM_BYTE  = 3'b001,
    CVA_AM_WORD  = 3'b010,
    CVA_AM_DWORD = 3'b100
  } cva_amode_t;

endpackage

// ### verilog/cva_addr_map.sv
// Purpose: maps the address counter to the display-memory address
// Assumes: inputs come from registers in the core and the display enable input, output is registered there
// Notes:   pure combinational; the row-scan substitution only acts while displaying
`timescale 1ns/1ns
module cva_addr_map (
  input  wire logic [15:0]         ma_i,
  input  wire logic [1:0]          row_i,
  input  wire logic                active_i,
  input  wire cva_pkg::cva_amode_t mode_i,
  input  wire logic                wrap_i,
  input  wire logic                compat_i,
  input  wire logic                rowsel_i,
  output logic      [15:0]         addr_o
);

  logic [15:0] rot;

  // rotation by mode, then row-scan bits replace bits 13 and 14
  always_comb begin
    unique case (mode_i)
      cva_pkg::CVA_AM_BYTE:  rot = ma_i;
      cva_pkg::CVA_AM_WORD:  rot = {ma_i[14:0], wrap_i ? ma_i[15] : ma_i[13]};
      cva_pkg::CVA_AM_DWORD: rot = {ma_i[13:0], ma_i[15:14]};
      default:               rot = ma_i;
    endcase
    addr_o = rot;
    // row bit 0 on bit 13 puts odd scan lines 8k bytes above the even ones
    if (active_i && !compat_i) begin
      addr_o[13] = row_i[0];
    end
    if (active_i && !rowsel_i) begin
      addr_o[14] = row_i[1];
    end
  end

endmodule

// ### verilog/cva_regs.sv
// Purpose: index and data port decode plus the five control registers
// Assumes: i/o strobes are one-cycle pulses synchronous to ref_clk_i
// Notes:   read data is registered and valid the cycle after io_rd_i
`timescale 1ns/1ns
module cva_regs (
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic       io_wr_i,
  input  wire logic       io_rd_i,
  input  wire logic [7:0] io_wdata_i,
  input  wire logic       color_emul_i,
  output logic      [7:0] io_rdata_o,
  cva_cfg_if.regs         cfg
);

  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] ul;
    logic [7:0] vbs;
    logic [7:0] vbe;
    logic [7:0] mode;
    logic [7:0] lcmp;
    logic [7:0] rdata;
  } cva_regs_st_t;

  cva_regs_st_t s_r;
  cva_regs_st_t s_nxt;
  logic         idx_hit;
  logic         data_hit;
  logic [7:0]   sel_val;

  ////////////////////////////////////////////////////////////////////////////
  // port decode follows the emulation select
  assign idx_hit  = io_addr_i == (color_emul_i ? cva_pkg::CVA_IDX_PORT_COLOR
                                               : cva_pkg::CVA_IDX_PORT_MONO);
  assign data_hit = io_addr_i == (color_emul_i ? cva_pkg::CVA_DATA_PORT_COLOR
                                               : cva_pkg::CVA_DATA_PORT_MONO);

  // indices outside this block read as zero, other registers live elsewhere
  always_comb begin
    unique case (s_r.idx)
      cva_pkg::CVA_IDX_UNDERLINE: sel_val = s_r.ul;
      cva_pkg::CVA_IDX_VBSTART:   sel_val = s_r.vbs;
      cva_pkg::CVA_IDX_VBEND:     sel_val = s_r.vbe;
      cva_pkg::CVA_IDX_MODE:      sel_val = s_r.mode;
      cva_pkg::CVA_IDX_LCOMPARE:  sel_val = s_r.lcmp;
      default:                    sel_val = 8'h00;
    endcase
  end

  // writes are masked so reserved bits never leave zero
  always_comb begin
    s_nxt = s_r;
    if (io_wr_i && idx_hit) begin
      s_nxt.idx = io_wdata_i;
    end
    if (io_wr_i && data_hit) begin
      unique case (s_r.idx)
        cva_pkg::CVA_IDX_UNDERLINE: s_nxt.ul   = io_wdata_i & cva_pkg::CVA_MASK_UNDERLINE;
        cva_pkg::CVA_IDX_VBSTART:   s_nxt.vbs  = io_wdata_i & cva_pkg::CVA_MASK_VBSTART;
        cva_pkg::CVA_IDX_VBEND:     s_nxt.vbe  = io_wdata_i & cva_pkg::CVA_MASK_VBEND;
        cva_pkg::CVA_IDX_MODE:      s_nxt.mode = io_wdata_i & cva_pkg::CVA_MASK_MODE;
        cva_pkg::CVA_IDX_LCOMPARE:  s_nxt.lcmp = io_wdata_i & cva_pkg::CVA_MASK_LCOMPARE;
        default:                    s_nxt.idx  = s_r.idx;
      endcase
    end
    if (io_rd_i) begin
      s_nxt.rdata = idx_hit ? s_r.idx : (data_hit ? sel_val : 8'h00);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_r <= '{cva_pkg::CVA_RST_INDEX, cva_pkg::CVA_RST_UNDERLINE, cva_pkg::CVA_RST_VBSTART,
               cva_pkg::CVA_RST_VBEND, cva_pkg::CVA_RST_MODE, cva_pkg::CVA_RST_LCOMPARE, 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign io_rdata_o = s_r.rdata;
  assign cfg.ul     = s_r.ul;
  assign cfg.vbs    = s_r.vbs;
  assign cfg.vbe    = s_r.vbe;
  assign cfg.mode   = s_r.mode;
  assign cfg.lcmp   = s_r.lcmp;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_wrong_port_ignored: assert property ((io_wr_i && !data_hit && !idx_hit) |=> $stable(s_r.mode))
    else $error("write to the inactive port pair changed a register");
  chk_reserved_zero: assert property (!s_r.ul[7] && !s_r.vbe[7] && !s_r.mode[4])
    else $error("reserved register bit not zero");

endmodule

// ### verilog/cva_top.sv
// Purpose: vertical counters, blanking, split screen and memory address generation
// Assumes: horizontal timing outside supplies char clock and line end pulses and the display enable level
// Notes:   overflow bits and scan limit arrive as plain inputs from their own registers
`timescale 1ns/1ns

module cva_top (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [7:0]  io_wdata_i,
  input  wire logic        color_emul_i,
  input  wire logic [1:0]  vbs_hi_i,
  input  wire logic [1:0]  lcmp_hi_i,
  input  wire logic [4:0]  max_scan_i,
  input  wire logic [9:0]  vtotal_i,
  input  wire logic [15:0] start_addr_i,
  input  wire logic [7:0]  line_offset_i,
  input  wire logic        char_clk_en_i,
  input  wire logic        line_end_i,
  input  wire logic        disp_en_i,
  input  wire logic        pan_compat_i,
  input  wire logic [3:0]  pan_i,
  output logic      [7:0]  io_rdata_o,
  output logic      [15:0] mem_addr_o,
  output logic             vblank_o,
  output logic             underline_o,
  output logic             split_o,
  output logic      [3:0]  pan_o,
  output logic      [9:0]  scan_line_o
);

  typedef struct packed {
    logic [9:0]  vcount;
    logic [4:0]  row;
    logic [15:0] line_base;
    logic [15:0] ma;
    logic [1:0]  div;
    logic        vblank;
    logic        split;
    logic        underline;
    logic [15:0] addr;
    logic [3:0]  pan;
  } cva_core_st_t;

  cva_core_st_t        s_r;
  cva_core_st_t        s_nxt;
  cva_cfg_if           cfg ();
  cva_pkg::cva_amode_t amode;
  logic [15:0]         addr_map;
  logic [9:0]          vbs_full;
  logic [9:0]          lcmp_full;
  logic [9:0]          vnext;
  logic [15:0]         line_step;
  logic                cnt4;
  logic                cnt2;
  logic                run;
  logic                ma_step;
  logic                frame_end;

  ////////////////////////////////////////////////////////////////////////////
  // register file
  cva_regs u_regs (
    .ref_clk_i    (ref_clk_i),
    .sys_rst_i    (sys_rst_i),
    .io_addr_i    (io_addr_i),
    .io_wr_i      (io_wr_i),
    .io_rd_i      (io_rd_i),
    .io_wdata_i   (io_wdata_i),
    .color_emul_i (color_emul_i),
    .io_rdata_o   (io_rdata_o),
    .cfg          (cfg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decoded fields
  assign vbs_full  = {vbs_hi_i, cfg.vbs};
  assign lcmp_full = {lcmp_hi_i, cfg.lcmp};
  assign cnt4      = cfg.ul[cva_pkg::CVA_UL_CNT4_BIT];
  assign cnt2      = cfg.mode[cva_pkg::CVA_MODE_CNT2];
  assign run       = cfg.mode[cva_pkg::CVA_MODE_RUN];
  assign frame_end = s_r.vcount == vtotal_i;
  assign vnext     = frame_end ? 10'h000 : s_r.vcount + 10'h001;
  // the counter counts characters, so a line step is twice the offset
  assign line_step = {7'h00, line_offset_i, 1'b0};

  // count-by-four wins over count-by-two; both clear means every clock
  always_comb begin
    if (cnt4) begin
      ma_step = s_r.div == cva_pkg::CVA_DIV4_LAST;
    end else if (cnt2) begin
      ma_step = s_r.div[0];
    end else begin
      ma_step = 1'b1;
    end
  end

  // double-word overrides the byte/word select
  always_comb begin
    if (cfg.ul[cva_pkg::CVA_UL_DWORD_BIT]) begin
      amode = cva_pkg::CVA_AM_DWORD;
    end else if (cfg.mode[cva_pkg::CVA_MODE_BYTE]) begin
      amode = cva_pkg::CVA_AM_BYTE;
    end else begin
      amode = cva_pkg::CVA_AM_WORD;
    end
  end

  cva_addr_map u_map (
    .ma_i     (s_r.ma),
    .row_i    (s_r.row[1:0]),
    .active_i (disp_en_i),
    .mode_i   (amode),
    .wrap_i   (cfg.mode[cva_pkg::CVA_MODE_WRAP]),
    .compat_i (cfg.mode[cva_pkg::CVA_MODE_COMPAT]),
    .rowsel_i (cfg.mode[cva_pkg::CVA_MODE_ROWSEL]),
    .addr_o   (addr_map)
  );

  ////////////////////////////////////////////////////////////////////////////
  // counter and blanking next state; with the run bit clear all counters hold at zero
  always_comb begin
    s_nxt = s_r;
    if (!run) begin
      s_nxt = '0;
    end else begin
      if (char_clk_en_i) begin
        s_nxt.div = s_r.div + 2'h1;
        if (ma_step && disp_en_i) begin
          s_nxt.ma = s_r.ma + 16'h0001;
        end
      end
      if (line_end_i) begin
        s_nxt.div    = 2'h0;
        s_nxt.vcount = vnext;
        if (frame_end) begin
          s_nxt.row       = 5'h00;
          s_nxt.line_base = start_addr_i;
          s_nxt.ma        = start_addr_i;
          s_nxt.split     = 1'b0;
        end else if (vnext == lcmp_full) begin
          // lower region ignores the start address, so it never scrolls
          s_nxt.row       = 5'h00;
          s_nxt.line_base = 16'h0000;
          s_nxt.ma        = 16'h0000;
          s_nxt.split     = 1'b1;
        end else if (s_r.row == max_scan_i) begin
          s_nxt.row       = 5'h00;
          s_nxt.line_base = s_r.line_base + line_step;
          s_nxt.ma        = s_r.line_base + line_step;
        end else begin
          s_nxt.row = s_r.row + 5'h01;
          s_nxt.ma  = s_r.line_base;
        end
        // start has priority if start and end land on one line
        if (vnext == vbs_full) begin
          s_nxt.vblank = 1'b1;
        end else if (vnext[cva_pkg::CVA_VBE_MSB:0] == cfg.vbe[cva_pkg::CVA_VBE_MSB:0]) begin
          s_nxt.vblank = 1'b0;
        end
      end
      s_nxt.underline = s_r.row == cfg.ul[cva_pkg::CVA_UL_ROW_MSB:0];
      s_nxt.addr      = addr_map;
      // with the compatibility setting the lower region is not panned
      s_nxt.pan       = (s_r.split && pan_compat_i) ? 4'h0 : pan_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mem_addr_o  = s_r.addr;
  assign vblank_o    = s_r.vblank;
  assign underline_o = s_r.underline;
  assign split_o     = s_r.split;
  assign pan_o       = s_r.pan;
  assign scan_line_o = s_r.vcount;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_ma_hold;
    (run && char_clk_en_i && !line_end_i && cnt4 && s_r.div != cva_pkg::CVA_DIV4_LAST) |=> $stable(s_r.ma);
  endproperty
  chk_div4_hold: assert property (p_ma_hold)
    else $error("address counter moved off the fourth character clock");
  chk_div1_step: assert property ((run && char_clk_en_i && disp_en_i && !line_end_i && !cnt4 && !cnt2)
    |=> s_r.ma == $past(s_r.ma) + 16'h0001)
    else $error("address counter missed a character clock");
  chk_div2_hold: assert property ((run && char_clk_en_i && !line_end_i && !cnt4 && cnt2 && !s_r.div[0])
    |=> $stable(s_r.ma))
    else $error("address counter moved on an even character clock");
  chk_vblank_start: assert property ((run && line_end_i && vnext == vbs_full) |=> vblank_o)
    else $error("vertical blanking did not begin at start line");
  chk_vblank_end: assert property ((run && line_end_i && vnext != vbs_full
    && vnext[6:0] == cfg.vbe[6:0]) |=> !vblank_o ##1 (!vblank_o || $past(line_end_i)))
    else $error("vertical blanking did not end at end match");
  chk_split_clear: assert property ((run && line_end_i && !frame_end && vnext == lcmp_full)
    |=> (s_r.ma == 16'h0000 && s_r.row == 5'h00 && split_o))
    else $error("line compare did not clear the counters");
  chk_underline_row: assert property ((run && s_r.row == cfg.ul[4:0]) |=> underline_o)
    else $error("underline missing on programmed row");
  chk_bit13_subst: assert property ((run && disp_en_i && !cfg.mode[0]) |=> mem_addr_o[13] == $past(s_r.row[0]))
    else $error("row bit 0 not on address bit 13");
  chk_bit14_subst: assert property ((run && disp_en_i && !cfg.mode[1]) |=> mem_addr_o[14] == $past(s_r.row[1]))
    else $error("row bit 1 not on address bit 14");
  chk_word_wrap: assert property ((run && amode == cva_pkg::CVA_AM_WORD)
    |=> mem_addr_o[0] == ($past(cfg.mode[5]) ? $past(s_r.ma[15]) : $past(s_r.ma[13])))
    else $error("word mode wrap bit wrong");
  chk_dword_rot: assert property ((run && cfg.ul[6]) |=> mem_addr_o[1:0] == $past(s_r.ma[15:14]))
    else $error("double-word rotation wrong");
  chk_split_pan: assert property ((run && s_r.split && pan_compat_i) |=> pan_o == 4'h0)
    else $error("lower region panned under compatibility setting");

  cov_split_entry: cover property (run && line_end_i && !frame_end && vnext == lcmp_full);
  cov_vblank_rise: cover property (!vblank_o ##1 vblank_o);
  cov_dword_run:   cover property (run && cnt4 && cfg.ul[6] && char_clk_en_i && disp_en_i);
  cov_frame_wrap:  cover property (run && line_end_i && frame_end);

endmodule
